// ### pkg/osc_defines.svh
/*
 Bit positions and reset values of the oscillator control bytes.
 Assumes inclusion by bare name from packages and modules.
*/
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH

// control byte 0
`define OSC_C0_DRIVE_BIT 1
`define OSC_C0_MSTOP_BIT 2
`define OSC_C0_SYSSEL_BIT 3
`define OSC_C0_PINEN_BIT 4
`define OSC_C0_RESET 8'h02

// control byte 1
`define OSC_C1_DIVSEL_BIT 0
`define OSC_C1_MEXT_BIT 1
`define OSC_C1_SEXT_BIT 2
`define OSC_C1_PRESC_BIT 7
`define OSC_C1_RESET 8'h00

// port function byte
`define OSC_PF_SUBOUT_BIT 1
`define OSC_PF_RESET 8'h00

// counter widths
`define OSC_MAIN_DIV_W 4
`define OSC_SUB_DIV_W 1
`define OSC_PRESC_W 5

`endif

// ### pkg/osc_pkg.sv
/*
 Types for the dual oscillator clock select block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package osc_pkg;

   typedef enum logic [2:0] {
      SEL_MAIN_DIV2 = 3'b000,
      SEL_MAIN = 3'b001,
      SEL_SLOW16 = 3'b010,
      SEL_SLOW8 = 3'b011,
      SEL_SUB = 3'b100
   } clk_sel_t;

   typedef enum logic {
      ST_RUN = 1'b0,
      ST_PARK = 1'b1
   } sw_state_t;

   typedef struct packed {
      logic pin_en;
      logic sys_sel;
      logic main_stop;
      logic drive_high;
      logic div_sel;
      logic main_ext;
      logic sub_ext;
      logic sub_out_sel;
   } osc_ctrl_t;

   typedef struct packed {
      logic main_osc_enable;
      logic sub_osc_enable;
      logic subin_is_osc;
      logic subout_is_osc;
      logic sub_drive_high;
   } osc_pins_t;

   typedef struct packed {
      osc_ctrl_t ctrl;
      osc_pins_t pins;
      clk_sel_t active;
      sw_state_t state;
      logic sysclk;
      logic f2;
      logic subpin;
      logic subpin_oe_n;
   } osc_state_t;

endpackage

// ### rtl/pin_sync.sv
/*
 Two-flop synchroniser for an oscillator pin with rising edge pulse.
 Assumes the pin is far slower than the sampling clock.
*/
`timescale 1ns/1ns
`default_nettype none

module pin_sync (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // pin and results
   input wire logic pin_in,
   output logic level,
   output logic rise
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } sync_st_t;

   sync_st_t q, d;

   always_comb begin
      d.s1 = pin_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign level = q.s2;
   assign rise = q.s2 & ~q.s3;

endmodule // pin_sync

`default_nettype wire

// ### rtl/tick_counter.sv
/*
 Free counter of tick pulses with clear and registered wrap pulse.
 Assumes tick and clr come from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module tick_counter #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   input wire logic clr,
   input wire logic tick,
   // results
   output logic [WIDTH-1:0] count,
   output logic wrap
);

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic wrap;
   } cnt_st_t;

   cnt_st_t q, d;

   always_comb begin
      d = q;
      d.wrap = 1'b0;
      if (clr) begin
         d.cnt = '0;
      end else if (tick) begin
         d.cnt = WIDTH'(q.cnt + 1'b1);
         d.wrap = &q.cnt;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign count = q.cnt;
   assign wrap = q.wrap;

endmodule // tick_counter

`default_nettype wire

// ### rtl/osc_clock_select.sv
/*
 Clock source selection for a main and a sub oscillator: control bits,
 pin steering, divide chains, glitch-free switch of system clock and f2,
 divide-by-32 prescaler.
 Assumes oscillator levels arrive on pins far slower than sys_clk and
 that software honours the ordering of writes.
*/
`timescale 1ns/1ns
`default_nettype none

`include "osc_defines.svh"

// Notes on behaviour
// - reset: main oscillator only, sub pins GPIO
// - pin enable set starts sub oscillator
// - main external input stops main oscillator
// - sub external input keeps out pin GPIO
// - sub clock driven out when both selected
// - no sub: f2 main/2, main, /16, /8
// - sub selected: system sub, f2 sub/2
// - main system clock: divide bit picks f2
// - pin enable sticky until reset
// - pin enable and select not together
// - stop and drive writes need pin enable
// - main stop halts, clear restarts main
// - select bit switches system clock source
// - drive strength resets high, software lowers
// - pin enable resets to zero
// - dummy write bit 7 clears prescaler
module osc_clock_select
   import osc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // control writes
   input wire logic ctrl0_wr,
   input wire logic ctrl1_wr,
   input wire logic port_func_wr,
   input wire logic [7:0] wr_data,
   // control readback
   output logic [7:0] ctrl0_rd,
   output logic [7:0] ctrl1_rd,
   output logic [7:0] port_func_rd,
   // oscillator pins
   input wire logic main_osc_in,
   input wire logic sub_osc_in,
   output var osc_pins_t pins,
   // shared sub clock output pin
   input wire logic port_pin_data,
   input wire logic port_pin_dir,
   output logic subclk_output_pin,
   output logic subclk_output_pin_oe_n,
   // derived clocks
   output logic sysclk_out,
   output logic f2_out,
   output logic fc32_tick
);

   localparam logic [7:0] C0R = `OSC_C0_RESET;
   localparam logic [7:0] C1R = `OSC_C1_RESET;
   localparam logic [7:0] PFR = `OSC_PF_RESET;

   localparam osc_state_t ST_RESET = '{
      ctrl: '{
         pin_en: C0R[`OSC_C0_PINEN_BIT],
         sys_sel: C0R[`OSC_C0_SYSSEL_BIT],
         main_stop: C0R[`OSC_C0_MSTOP_BIT],
         drive_high: C0R[`OSC_C0_DRIVE_BIT],
         div_sel: C1R[`OSC_C1_DIVSEL_BIT],
         main_ext: C1R[`OSC_C1_MEXT_BIT],
         sub_ext: C1R[`OSC_C1_SEXT_BIT],
         sub_out_sel: PFR[`OSC_PF_SUBOUT_BIT]
      },
      pins: '{
         main_osc_enable: 1'b1,
         sub_osc_enable: 1'b0,
         subin_is_osc: 1'b0,
         subout_is_osc: 1'b0,
         sub_drive_high: C0R[`OSC_C0_DRIVE_BIT]
      },
      active: SEL_MAIN_DIV2,
      state: ST_RUN,
      sysclk: 1'b0,
      f2: 1'b0,
      subpin: 1'b0,
      subpin_oe_n: 1'b1
   };

   osc_state_t q, d;
   logic main_lvl;
   logic main_rise;
   logic sub_lvl;
   logic sub_rise;
   logic [`OSC_MAIN_DIV_W-1:0] main_cnt;
   logic [`OSC_SUB_DIV_W-1:0] sub_cnt;
   logic [`OSC_PRESC_W-1:0] presc_cnt;
   logic main_tick;
   logic sub_tick;
   logic presc_tick;
   logic presc_clr;
   clk_sel_t req;
   logic [1:0] lv_act;
   logic [1:0] lv_req;

   // oscillator pins into the clock domain
   pin_sync u_main_sync (
      .clk(sys_clk),
      .reset(reset),
      .pin_in(main_osc_in),
      .level(main_lvl),
      .rise(main_rise)
   );
   pin_sync u_sub_sync (
      .clk(sys_clk),
      .reset(reset),
      .pin_in(sub_osc_in),
      .level(sub_lvl),
      .rise(sub_rise)
   );

   // divide chains
   assign main_tick = main_rise & ~q.ctrl.main_stop;
   assign sub_tick = sub_rise & q.ctrl.pin_en;
   assign presc_tick = q.ctrl.pin_en ? sub_rise : main_tick;
   assign presc_clr = ctrl1_wr & wr_data[`OSC_C1_PRESC_BIT];

   tick_counter #(.WIDTH(`OSC_MAIN_DIV_W)) u_main_div (
      .clk(sys_clk),
      .reset(reset),
      .clr(1'b0),
      .tick(main_tick),
      .count(main_cnt),
      .wrap()
   );
   tick_counter #(.WIDTH(`OSC_SUB_DIV_W)) u_sub_div (
      .clk(sys_clk),
      .reset(reset),
      .clr(~q.ctrl.pin_en),
      .tick(sub_tick),
      .count(sub_cnt),
      .wrap()
   );
   tick_counter #(.WIDTH(`OSC_PRESC_W)) u_presc (
      .clk(sys_clk),
      .reset(reset),
      .clr(presc_clr),
      .tick(presc_tick),
      .count(presc_cnt),
      .wrap(fc32_tick)
   );

   // levels {system clock, f2} for one selection
   function automatic logic [1:0] src_levels(
      input clk_sel_t sel,
      input logic m,
      input logic [`OSC_MAIN_DIV_W-1:0] mc,
      input logic s,
      input logic sc
   );
      logic [1:0] r;
      r = 2'b00;
      case (sel)
         SEL_MAIN_DIV2: r = {m, mc[0]};
         SEL_MAIN: r = {m, m};
         SEL_SLOW16: r = {mc[2], mc[3]};
         SEL_SLOW8: r = {mc[2], mc[2]};
         SEL_SUB: r = {s, sc};
         default: r = 2'b00;
      endcase
      return r;
   endfunction

   // requested source from the control bits
   always_comb begin
      if (q.ctrl.pin_en && q.ctrl.sys_sel) begin
         req = SEL_SUB;
      end else if (q.ctrl.sys_sel) begin
         req = q.ctrl.div_sel ? SEL_SLOW8 : SEL_SLOW16;
      end else begin
         req = q.ctrl.div_sel ? SEL_MAIN : SEL_MAIN_DIV2;
      end
   end

   assign lv_act = src_levels(q.active, main_lvl, main_cnt, sub_lvl, sub_cnt[0]);
   assign lv_req = src_levels(req, main_lvl, main_cnt, sub_lvl, sub_cnt[0]);

   always_comb begin
      d = q;
      // control byte 0
      if (ctrl0_wr) begin
         d.ctrl.pin_en = q.ctrl.pin_en | wr_data[`OSC_C0_PINEN_BIT];
         if (!(wr_data[`OSC_C0_PINEN_BIT] && wr_data[`OSC_C0_SYSSEL_BIT]
               && !q.ctrl.pin_en)) begin
            d.ctrl.sys_sel = wr_data[`OSC_C0_SYSSEL_BIT];
         end
         if (q.ctrl.pin_en) begin
            d.ctrl.main_stop = wr_data[`OSC_C0_MSTOP_BIT];
            d.ctrl.drive_high = wr_data[`OSC_C0_DRIVE_BIT];
         end
      end
      // control byte 1, prescaler bit is write only
      if (ctrl1_wr) begin
         d.ctrl.div_sel = wr_data[`OSC_C1_DIVSEL_BIT];
         d.ctrl.main_ext = wr_data[`OSC_C1_MEXT_BIT];
         d.ctrl.sub_ext = wr_data[`OSC_C1_SEXT_BIT];
      end
      if (port_func_wr) begin
         d.ctrl.sub_out_sel = wr_data[`OSC_PF_SUBOUT_BIT];
      end
      // pin steering follows the new control value
      d.pins.main_osc_enable = ~d.ctrl.main_ext & ~d.ctrl.main_stop;
      d.pins.sub_osc_enable = d.ctrl.pin_en & ~d.ctrl.sub_ext;
      d.pins.subin_is_osc = d.ctrl.pin_en;
      d.pins.subout_is_osc = d.ctrl.pin_en & ~d.ctrl.sub_ext;
      d.pins.sub_drive_high = d.ctrl.drive_high;
      if (d.ctrl.pin_en && d.ctrl.sub_out_sel) begin
         d.subpin = sub_lvl;
         d.subpin_oe_n = 1'b0;
      end else begin
         d.subpin = port_pin_data;
         d.subpin_oe_n = ~port_pin_dir;
      end
      // switch: park both outputs low, adopt new source at its low phase
      case (q.state)
         ST_RUN: begin
            if (req != q.active && !q.sysclk && !q.f2) begin
               d.state = ST_PARK;
            end else if (req == q.active || q.sysclk || q.f2) begin
               d.sysclk = (req != q.active) ? (q.sysclk & lv_act[1]) : lv_act[1];
               d.f2 = (req != q.active) ? (q.f2 & lv_act[0]) : lv_act[0];
            end
         end
         ST_PARK: begin
            d.sysclk = 1'b0;
            d.f2 = 1'b0;
            if (lv_req == 2'b00) begin
               d.active = req;
               d.state = ST_RUN;
            end
         end
         default: begin
            d.state = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q <= ST_RESET;
      end else begin
         q <= d;
      end
   end

   // outputs
   assign pins = q.pins;
   assign subclk_output_pin = q.subpin;
   assign subclk_output_pin_oe_n = q.subpin_oe_n;
   assign sysclk_out = q.sysclk;
   assign f2_out = q.f2;

   always_comb begin
      ctrl0_rd = 8'h00;
      ctrl0_rd[`OSC_C0_PINEN_BIT] = q.ctrl.pin_en;
      ctrl0_rd[`OSC_C0_SYSSEL_BIT] = q.ctrl.sys_sel;
      ctrl0_rd[`OSC_C0_MSTOP_BIT] = q.ctrl.main_stop;
      ctrl0_rd[`OSC_C0_DRIVE_BIT] = q.ctrl.drive_high;
      ctrl1_rd = 8'h00;
      ctrl1_rd[`OSC_C1_DIVSEL_BIT] = q.ctrl.div_sel;
      ctrl1_rd[`OSC_C1_MEXT_BIT] = q.ctrl.main_ext;
      ctrl1_rd[`OSC_C1_SEXT_BIT] = q.ctrl.sub_ext;
      port_func_rd = 8'h00;
      port_func_rd[`OSC_PF_SUBOUT_BIT] = q.ctrl.sub_out_sel;
   end

   // checks
   sequence both_set_s;
      ctrl0_wr && !q.ctrl.pin_en && !q.ctrl.sys_sel
         && wr_data[`OSC_C0_PINEN_BIT] && wr_data[`OSC_C0_SYSSEL_BIT];
   endsequence
   sequence sel_later_s;
      ctrl0_wr && wr_data[`OSC_C0_SYSSEL_BIT];
   endsequence

   reset_state_a: assert property (@(posedge sys_clk) reset |=>
      !q.ctrl.pin_en && !q.pins.subin_is_osc && q.pins.main_osc_enable
         && q.active == SEL_MAIN_DIV2)
      else $error("reset state wrong");
   drive_reset_a: assert property (@(posedge sys_clk) reset |=>
      q.ctrl.drive_high && ctrl0_rd[`OSC_C0_DRIVE_BIT])
      else $error("drive bit not high after reset");
   pin_start_a: assert property (@(posedge sys_clk) disable iff (reset)
      ctrl0_wr && wr_data[`OSC_C0_PINEN_BIT] |=> q.pins.subin_is_osc
         && (q.pins.sub_osc_enable == !q.ctrl.sub_ext))
      else $error("sub oscillator not started");
   pin_sticky_a: assert property (@(posedge sys_clk) disable iff (reset)
      q.ctrl.pin_en |=> q.ctrl.pin_en [*3])
      else $error("pin enable cleared");
   single_write_a: assert property (@(posedge sys_clk) disable iff (reset)
      both_set_s |=> q.ctrl.pin_en && !q.ctrl.sys_sel)
      else $error("both bits set in one write");
   sel_second_a: assert property (@(posedge sys_clk) disable iff (reset)
      q.ctrl.pin_en ##0 sel_later_s |=> q.ctrl.sys_sel)
      else $error("select not taken after pin enable");
   ignore_write_a: assert property (@(posedge sys_clk) disable iff (reset)
      ctrl0_wr && !q.ctrl.pin_en |=> $stable(q.ctrl.main_stop)
         && $stable(q.ctrl.drive_high))
      else $error("write not ignored");
   ext_pins_a: assert property (@(posedge sys_clk) disable iff (reset)
      (!(q.ctrl.main_ext || q.ctrl.main_stop) || !q.pins.main_osc_enable)
         && (!q.ctrl.sub_ext || !q.pins.subout_is_osc))
      else $error("oscillator pin steering wrong");
   sub_out_a: assert property (@(posedge sys_clk) disable iff (reset)
      q.ctrl.pin_en && q.ctrl.sub_out_sel |-> !q.subpin_oe_n
         && q.subpin == $past(sub_lvl))
      else $error("sub clock not driven out");
   presc_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
      presc_clr |=> presc_cnt == '0)
      else $error("prescaler not cleared");
   glitch_free_a: assert property (@(posedge sys_clk) disable iff (reset)
      $changed(q.active) |-> !$past(q.sysclk) && !$past(q.f2)
         && !q.sysclk && !q.f2)
      else $error("source changed while clock high");
   sub_sel_a: assert property (@(posedge sys_clk) disable iff (reset)
      q.ctrl.pin_en && q.ctrl.sys_sel && q.state == ST_RUN
         && q.active == SEL_SUB |=> q.f2 == $past(sub_cnt[0]))
      else $error("f2 not sub clock over two");

endmodule // osc_clock_select

`default_nettype wire

// ### testbench/osc_source.sv
/*
 Oscillator or external clock source model: a level that toggles every
 HALF_NS while run is high and holds still while run is low.
 Assumes run comes from the device's enable pins or from the bench.
*/
`timescale 1ns/1ns
`default_nettype none

module osc_source #(
   parameter int HALF_NS = 410
) (
   // control
   input wire logic run,
   // oscillator level
   output logic osc
);
   initial osc = 1'b0;
   // a stopped resonator holds its level
   always begin
      if (run) #(HALF_NS) osc = ~osc;
      else @(posedge run);
   end
endmodule // osc_source

`default_nettype wire

// ### testbench/testbench.sv
/*
 Self-checking bench for osc_clock_select: control writes, pin steering,
 clock ratios, sub clock output and prescaler clear.
 Assumes osc_source as the resonators and the design's synchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench;
   import osc_pkg::*;
   localparam logic [29:0] RST_VEC = {8'h02, 8'h00, 8'h00, 5'h11, 1'h1};
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic ctrl0_wr = 1'b0, ctrl1_wr = 1'b0, port_func_wr = 1'b0;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] ctrl0_rd, ctrl1_rd, port_func_rd;
   osc_pins_t pins;
   logic port_pin_data = 1'b0, port_pin_dir = 1'b0;
   logic subclk_output_pin, subclk_output_pin_oe_n, sysclk_out, f2_out, fc32_tick;
   logic main_osc_in, sub_osc_in;
   logic ext_main = 1'b0, ext_sub = 1'b0;
   logic probe = 1'b0, took = 1'b0, arm = 1'b0, started = 1'b0, sig, sig_q = 1'b0;
   int msel = 0, cnt = 0, n_fail = 0, checked = 0;
   logic [29:0] exp_rb[$];
   real exp_per[$], exp_tol[$];

   always #25 sys_clk = ~sys_clk;

   osc_source #(.HALF_NS(410)) main_src (.run(pins.main_osc_enable | ext_main), .osc(main_osc_in));
   osc_source #(.HALF_NS(6010)) sub_src (.run(pins.sub_osc_enable | ext_sub), .osc(sub_osc_in));

   osc_clock_select dut (
      .sys_clk(sys_clk), .reset(reset),
      .ctrl0_wr(ctrl0_wr), .ctrl1_wr(ctrl1_wr), .port_func_wr(port_func_wr),
      .wr_data(wr_data), .ctrl0_rd(ctrl0_rd), .ctrl1_rd(ctrl1_rd),
      .port_func_rd(port_func_rd), .main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in),
      .pins(pins), .port_pin_data(port_pin_data), .port_pin_dir(port_pin_dir),
      .subclk_output_pin(subclk_output_pin), .subclk_output_pin_oe_n(subclk_output_pin_oe_n),
      .sysclk_out(sysclk_out), .f2_out(f2_out), .fc32_tick(fc32_tick)
   );

   always_comb begin
      case (msel)
         0: sig = f2_out;
         1: sig = sysclk_out;
         2: sig = subclk_output_pin;
         default: sig = fc32_tick;
      endcase
   end

   task automatic give_verdict();
      if (n_fail == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check_rb();
      logic [29:0] e;
      logic [30:0] got;
      e = exp_rb.pop_front();
      // note bit 0 set: shared pin follows its port latch and direction
      got = {ctrl0_rd, ctrl1_rd, port_func_rd, pins, subclk_output_pin_oe_n,
         e[0] & subclk_output_pin};
      checked++;
      if (got !== {e[29:1], e[0] & ~port_pin_dir, e[0] & port_pin_data}) begin
         n_fail++;
         $display("MISMATCH %0t control state %h expected %h", $time, got, e);
      end
   endtask

   task automatic check_per(input int c);
      real e;
      real t;
      e = exp_per.pop_front();
      t = exp_tol.pop_front();
      checked++;
      if (c > e + t || c < e - t) begin
         n_fail++;
         $display("MISMATCH %0t clock %0d period %0d expected %0.1f", $time, msel, c, e);
      end
   endtask

   // watcher: readback after each taken write, periods while armed
   always @(posedge sys_clk) begin
      took <= probe | (~reset & (ctrl0_wr | ctrl1_wr | port_func_wr));
      if (arm) begin
         cnt++;
         if (sig & ~sig_q) begin
            if (started) begin
               check_per(cnt);
               arm = 1'b0;
            end else begin
               started = 1'b1;
               cnt = 0;
            end
         end
      end
      sig_q = sig;
   end

   always @(negedge sys_clk) if (took) check_rb();

   task automatic wr(input int r, input logic [7:0] d, input logic [29:0] e);
      @(negedge sys_clk);
      exp_rb.push_back(e);
      wr_data = d;
      port_pin_data = 1'($urandom);
      port_pin_dir = 1'($urandom);
      ctrl0_wr = (r == 0);
      ctrl1_wr = (r == 1);
      port_func_wr = (r == 2);
      @(negedge sys_clk);
      ctrl0_wr = 1'b0;
      ctrl1_wr = 1'b0;
      port_func_wr = 1'b0;
   endtask

   task automatic peek(input logic [29:0] e);
      @(negedge sys_clk);
      exp_rb.push_back(e);
      probe = 1'b1;
      @(negedge sys_clk);
      probe = 1'b0;
   endtask

   task automatic meas(input int s, input real e, input real t, input int settle, input bit now);
      int lim;
      lim = 0;
      msel = s;
      repeat (settle) @(negedge sys_clk);
      exp_per.push_back(e);
      exp_tol.push_back(t);
      started = now;
      cnt = 0;
      arm = 1'b1;
      while (arm && lim < 4 * e + 600) begin
         @(negedge sys_clk);
         lim++;
      end
      if (arm) begin
         n_fail++;
         $display("MISMATCH %0t no edge on watched clock %0d", $time, s);
         give_verdict();
      end
   endtask

   task automatic do_reset();
      @(negedge sys_clk);
      reset = 1'b1;
      repeat (10) @(negedge sys_clk);
      reset = 1'b0;
   endtask

   initial begin
      logic [7:0] d;
      void'($urandom(32'h3824));
      do_reset();
      peek(RST_VEC);
      wr(0, 8'h06, RST_VEC);
      for (int i = 0; i < 4; i++) begin
         wr(1, {7'h00, i[0]}, {4'h0, i[1] & i[0], 3'h2, 7'h00, i[0], 8'h00, 5'h11, 1'h1});
         wr(0, {4'h0, i[1], 3'h0}, {4'h0, i[1], 3'h2, 7'h00, i[0], 8'h00, 5'h11, 1'h1});
         meas(0, 16.4 * (i[1] ? (i[0] ? 8 : 16) : (i[0] ? 1 : 2)), 1.5, 600, 0);
         if (i[1]) meas(1, 131.2, 1.5, 0, 0);
      end
      wr(0, 8'h00, {8'h02, 8'h01, 8'h00, 5'h11, 1'h1});
      repeat ($urandom % 40) @(negedge sys_clk);
      wr(1, 8'h80, RST_VEC);
      meas(3, 520.0, 16.0, 0, 1);
      wr(0, 8'h18, {8'h12, 8'h00, 8'h00, 5'h1F, 1'h1});
      repeat (2000) @(negedge sys_clk); // sub oscillation settles
      wr(0, 8'h10, {8'h10, 8'h00, 8'h00, 5'h1E, 1'h1});
      wr(2, 8'h02, {8'h10, 8'h00, 8'h02, 5'h1E, 1'h0});
      meas(2, 240.4, 1.5, 300, 0);
      wr(0, 8'h18, {8'h18, 8'h00, 8'h02, 5'h1E, 1'h0});
      meas(0, 480.8, 2.0, 1500, 0);
      meas(1, 240.4, 2.0, 0, 0);
      wr(1, 8'h01, {8'h18, 8'h01, 8'h02, 5'h1E, 1'h0});
      meas(0, 480.8, 2.0, 500, 0);
      wr(0, 8'h1C, {8'h1C, 8'h01, 8'h02, 5'h0E, 1'h0});
      wr(0, 8'h18, {8'h18, 8'h01, 8'h02, 5'h1E, 1'h0});
      repeat (500) @(negedge sys_clk); // main oscillation settles
      wr(0, 8'h10, {8'h10, 8'h01, 8'h02, 5'h1E, 1'h0});
      meas(0, 16.4, 1.5, 1500, 0);
      ext_main = 1'b1;
      wr(1, 8'h03, {8'h10, 8'h03, 8'h02, 5'h0E, 1'h0});
      meas(0, 16.4, 1.5, 200, 0);
      wr(1, 8'h01, {8'h10, 8'h01, 8'h02, 5'h1E, 1'h0});
      ext_main = 1'b0;
      d = 8'($urandom) & 8'hE7;
      wr(0, d, {5'h02, d[2:1], 1'h0, 8'h01, 8'h02, ~d[2], 3'h7, d[1], 1'h0});
      do_reset();
      peek(RST_VEC);
      ext_sub = 1'b1;
      wr(1, 8'h04, {8'h02, 8'h04, 8'h00, 5'h11, 1'h1});
      wr(0, 8'h10, {8'h12, 8'h04, 8'h00, 5'h15, 1'h1});
      give_verdict();
   end
endmodule // testbench

`default_nettype wire
